// ### src/iblcl_consts.svh
`ifndef IBLCL_CONSTS_SVH
`define IBLCL_CONSTS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define IBLCL_ADDR_LEN    8'h00
`define IBLCL_ADDR_STAT   8'h01
// ----------------------------------------------------------------
// Length register layout and reset value
// ----------------------------------------------------------------
`define IBLCL_GEN_MSB     5
`define IBLCL_GEN_LSB     4
`define IBLCL_ACT_MSB     3
`define IBLCL_ACT_LSB     2
`define IBLCL_DEACT_MSB   1
`define IBLCL_DEACT_LSB   0
`define IBLCL_LEN_RST     6'h01
`define IBLCL_GEN_IDX_RST 3'h4
// ----------------------------------------------------------------
// Code lengths
// ----------------------------------------------------------------
`define IBLCL_LEN_BASE    4'h5
`define IBLCL_FILL_MAX    4'h8
`define IBLCL_MASK_FULL   8'hFF
`define IBLCL_SEL_MAX     2'h3
`endif

// ### src/iblcl_pkg.sv
`default_nettype none
package iblcl_pkg;
    // Length select codes shared by generator and both detectors
    typedef enum logic [1:0] {
        LEN5 = 2'b00,
        LEN6 = 2'b01,
        LEN7 = 2'b10,
        LEN8 = 2'b11
    } iblcl_len_e;

    // The three length selects as one carrier
    typedef struct packed {
        iblcl_len_e gen;
        iblcl_len_e act;
        iblcl_len_e deact;
    } iblcl_len_s;
endpackage
`default_nettype wire

// ### src/iblcl_top.sv
// What this block does
// - The generation length field picks 5 to 8 valid low-order pattern bits, 00 to 11.
// - After reset the generation length field is 00, so five pattern bits are sent.
// - The activate length field picks 5 to 8 low-order activate pattern bits to compare.
// - After reset the activate length field is 00, a five-bit activate code.
// - After reset the deactivate length field is 01, a six-bit deactivate code.
// - The generator sends bit 0 of the pattern as the last bit of each repetition.
// - The activate detector takes pattern bit 0 as the last received code bit.
// - The deactivate detector takes pattern bit 0 as the last received code bit.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "iblcl_consts.svh"

module iblcl_top (
    input  wire logic                   CLK_SYS,
    input  wire logic                   SRST,
    input  wire logic [7:0]             ADDR,
    input  wire logic [7:0]             WDATA,
    input  wire logic                   WR_STB,
    input  wire logic                   RD_STB,
    output logic      [7:0]             RDATA,
    input  wire logic [7:0]             GEN_PATTERN,
    input  wire logic [7:0]             ACT_PATTERN,
    input  wire logic [7:0]             DEACT_PATTERN,
    input  wire logic                   TX_BIT_EN,
    output logic                        TX_CODE_BIT,
    input  wire logic                   RX_BIT_EN,
    input  wire logic                   RX_BIT,
    output logic                        ACT_MATCH,
    output logic                        DEACT_MATCH,
    output iblcl_pkg::iblcl_len_s       LEN_SEL
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Mask of the valid low-order bits for a length select
    function automatic logic [7:0] len_mask(input iblcl_pkg::iblcl_len_e sel);
        len_mask = `IBLCL_MASK_FULL >> (`IBLCL_SEL_MAX - sel);
    endfunction

    // Number of valid bits for a length select
    function automatic logic [3:0] len_bits(input iblcl_pkg::iblcl_len_e sel);
        len_bits = `IBLCL_LEN_BASE + {2'h0, sel};
    endfunction

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    iblcl_pkg::iblcl_len_s len_cfg;
    iblcl_pkg::iblcl_len_s next_len_cfg;
    logic [7:0]            next_rdata;
    logic [2:0]            gen_idx;
    logic                  wr_len;

    assign wr_len = WR_STB && (ADDR == `IBLCL_ADDR_LEN);

    // Decode writes; unmapped reads answer zero, and data stand one cycle only
    always_comb begin
        next_len_cfg = len_cfg;
        next_rdata   = 8'h00;
        if (wr_len) begin
            next_len_cfg.gen   = iblcl_pkg::iblcl_len_e'(
                WDATA[`IBLCL_GEN_MSB:`IBLCL_GEN_LSB]);
            next_len_cfg.act   = iblcl_pkg::iblcl_len_e'(
                WDATA[`IBLCL_ACT_MSB:`IBLCL_ACT_LSB]);
            next_len_cfg.deact = iblcl_pkg::iblcl_len_e'(
                WDATA[`IBLCL_DEACT_MSB:`IBLCL_DEACT_LSB]);
        end
        if (RD_STB) begin
            if (ADDR == `IBLCL_ADDR_LEN) begin
                next_rdata = {2'h0, len_cfg};
            end else if (ADDR == `IBLCL_ADDR_STAT) begin
                next_rdata = {3'h0, gen_idx, DEACT_MATCH, ACT_MATCH};
            end
        end
    end

    // Reset values give 5/5/6-bit codes
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            len_cfg <= iblcl_pkg::iblcl_len_s'(`IBLCL_LEN_RST);
            RDATA   <= 8'h00;
        end else begin
            len_cfg <= next_len_cfg;
            RDATA   <= next_rdata;
        end
    end

    assign LEN_SEL = len_cfg;

    // ----------------------------------------------------------------
    // Code generator
    // ----------------------------------------------------------------
    logic [2:0] gen_last;
    logic [2:0] next_gen_idx;
    logic       next_tx_bit;

    assign gen_last = 3'(len_bits(len_cfg.gen) - 4'h1);

    // Bits go out from the top valid bit down to bit 0; a shorter length
    // written mid-repetition clamps the index so no stale upper bit leaks
    always_comb begin
        next_gen_idx = gen_idx;
        next_tx_bit  = TX_CODE_BIT;
        if (TX_BIT_EN) begin
            if (gen_idx > gen_last) begin
                next_tx_bit  = GEN_PATTERN[gen_last];
                next_gen_idx = gen_last - 3'h1;
            end else begin
                next_tx_bit  = GEN_PATTERN[gen_idx];
                if (gen_idx == 3'h0) begin
                    next_gen_idx = gen_last;
                end else begin
                    next_gen_idx = gen_idx - 3'h1;
                end
            end
        end
    end

    // Generator state
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            gen_idx     <= `IBLCL_GEN_IDX_RST;
            TX_CODE_BIT <= 1'b0;
        end else begin
            gen_idx     <= next_gen_idx;
            TX_CODE_BIT <= next_tx_bit;
        end
    end

    // ----------------------------------------------------------------
    // Code detectors
    // ----------------------------------------------------------------
    logic [7:0] rx_sh;
    logic [7:0] next_rx_sh;
    logic [3:0] rx_fill;
    logic [3:0] next_rx_fill;
    logic       next_act;
    logic       next_deact;
    logic [7:0] act_mask;
    logic [7:0] deact_mask;

    assign act_mask   = len_mask(len_cfg.act);
    assign deact_mask = len_mask(len_cfg.deact);

    // Newest bit lands in bit 0, so it lines up with pattern bit 0; the fill
    // count stops a match on a partly filled shifter after reset
    always_comb begin
        next_rx_sh   = rx_sh;
        next_rx_fill = rx_fill;
        next_act     = ACT_MATCH;
        next_deact   = DEACT_MATCH;
        if (RX_BIT_EN) begin
            next_rx_sh = {rx_sh[6:0], RX_BIT};
            if (rx_fill != `IBLCL_FILL_MAX) begin
                next_rx_fill = rx_fill + 4'h1;
            end
            next_act   = (((next_rx_sh ^ ACT_PATTERN) & act_mask) == 8'h00)
                         && (next_rx_fill >= len_bits(len_cfg.act));
            next_deact = (((next_rx_sh ^ DEACT_PATTERN) & deact_mask) == 8'h00)
                         && (next_rx_fill >= len_bits(len_cfg.deact));
        end
    end

    // Detector state
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rx_sh       <= 8'h00;
            rx_fill     <= 4'h0;
            ACT_MATCH   <= 1'b0;
            DEACT_MATCH <= 1'b0;
        end else begin
            rx_sh       <= next_rx_sh;
            rx_fill     <= next_rx_fill;
            ACT_MATCH   <= next_act;
            DEACT_MATCH <= next_deact;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    // Repetition restarts at the top valid bit
    a_gen_wrap_len: assert property (
        (TX_BIT_EN && gen_idx == 3'h0 && !wr_len) |=> gen_idx == $past(gen_last))
        else $error("generator did not restart at top valid bit");

    a_gen_reset_len: assert property (
        $past(SRST) |-> (len_cfg.gen == iblcl_pkg::LEN5 && gen_idx == `IBLCL_GEN_IDX_RST))
        else $error("generation length not five bits after reset");

    a_act_reset_len: assert property (
        $past(SRST) |-> len_cfg.act == iblcl_pkg::LEN5)
        else $error("activate length not five bits after reset");

    a_deact_reset_len: assert property (
        $past(SRST) |-> len_cfg.deact == iblcl_pkg::LEN6)
        else $error("deactivate length not six bits after reset");

    // Judged only on the cycle a bit lands; a match level may outlive a later length write
    a_act_fill_len: assert property (
        (RX_BIT_EN && !wr_len) ##1 ACT_MATCH |-> rx_fill >= len_bits(len_cfg.act))
        else $error("activate match with too few bits received");

    a_deact_fill_len: assert property (
        (RX_BIT_EN && !wr_len) ##1 DEACT_MATCH |-> rx_fill >= len_bits(len_cfg.deact))
        else $error("deactivate match with too few bits received");

    a_gen_bit0_last: assert property (
        (TX_BIT_EN && gen_idx == 3'h0) |=> TX_CODE_BIT == $past(GEN_PATTERN[0]))
        else $error("last bit of repetition is not pattern bit 0");

    a_act_bit0_last: assert property (
        $rose(ACT_MATCH) |-> $past(RX_BIT) == $past(ACT_PATTERN[0]))
        else $error("activate match without bit 0 as last bit");

    a_deact_bit0_last: assert property (
        $rose(DEACT_MATCH) |-> $past(RX_BIT) == $past(DEACT_PATTERN[0]))
        else $error("deactivate match without bit 0 as last bit");

    a_len_rsvd_zero: assert property (
        ($past(RD_STB) && $past(ADDR) == `IBLCL_ADDR_LEN) |-> RDATA[7:6] == 2'h0)
        else $error("reserved length bits read nonzero");

    c_act_hit: cover property (RX_BIT_EN ##1 $rose(ACT_MATCH));
    c_deact_hit: cover property (RX_BIT_EN ##1 $rose(DEACT_MATCH));
    c_gen_len8: cover property (len_cfg.gen == iblcl_pkg::LEN8 && TX_BIT_EN && gen_idx == 3'h0);

endmodule

`default_nettype wire

// ### tb/tb_inband_loop_code_length_cfg.sv
`timescale 1ns/10ps
`default_nettype none
`include "iblcl_consts.svh"
module tb_inband_loop_code_length_cfg;
    logic                  clk_sys = 1'b0;
    logic                  srst = 1'b1;
    logic                  wr_stb = 1'b0, rd_stb = 1'b0, tx_en = 1'b0, rx_en = 1'b0;
    logic                  rx_bit = 1'b0;
    logic [7:0]            addr = 8'h00, wdata = 8'h00, rdata, rd;
    logic [7:0]            gen_p = 8'hB5, act_p = 8'hA6, deact_p = 8'h59;
    logic                  tx_bit, act_m, deact_m;
    iblcl_pkg::iblcl_len_s len_sel;
    int                    n_mismatch = 0, n_tests = 0;

    // Free-running 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    iblcl_top dut_u (.CLK_SYS(clk_sys), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .GEN_PATTERN(gen_p),
        .ACT_PATTERN(act_p), .DEACT_PATTERN(deact_p), .TX_BIT_EN(tx_en),
        .TX_CODE_BIT(tx_bit), .RX_BIT_EN(rx_en), .RX_BIT(rx_bit), .ACT_MATCH(act_m),
        .DEACT_MATCH(deact_m), .LEN_SEL(len_sel));

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reset also restarts the generator index, so every scenario except t_fields starts from it
    task automatic do_reset();
        @(posedge clk_sys) srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys) wr_stb <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys) rd_stb <= 1'b0;
        #1 rd = rdata;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs();
        do_reset();
        chk({2'b00, len_sel}, 8'h01);
        reg_rd(`IBLCL_ADDR_LEN);
        chk(rd, 8'h01);
        reg_rd(`IBLCL_ADDR_STAT);
        chk(rd, 8'h10);
        reg_rd(8'h02);
        chk(rd, 8'h00);
        $display("test reset_regs done");
    endtask

    // Every code in all three fields, reserved bits written as ones
    task automatic t_fields();
        logic [7:0] d;
        for (int c = 0; c < 4; c++) begin
            d = 8'hC0 | (8'(c) * 8'h15);
            reg_wr(`IBLCL_ADDR_LEN, d);
            chk({2'b00, len_sel}, d & 8'h3F);
            reg_rd(`IBLCL_ADDR_LEN);
            chk(rd, d & 8'h3F);
        end
        reg_wr(`IBLCL_ADDR_STAT, 8'h00);
        chk({2'b00, len_sel}, 8'h3F);
        $display("test fields done");
    endtask

    // First pass starts at bit 4 after reset, then full passes; bit 0 last, upper bits unsent
    task automatic t_gen(input logic [1:0] code);
        int l, idx;
        do_reset();
        reg_wr(`IBLCL_ADDR_LEN, {2'b00, code, 4'h1});
        l = 5 + int'(code);
        idx = 4;
        @(posedge clk_sys) tx_en <= 1'b1;
        for (int i = 0; i < 2 * l; i++) begin
            @(posedge clk_sys);
            #1 chk({7'h00, tx_bit}, {7'h00, gen_p[idx]});
            idx = (idx == 0) ? l - 1 : idx - 1;
        end
        @(posedge clk_sys) tx_en <= 1'b0;
        $display("test gen done");
    endtask

    // Feed the selected pattern oldest bit first; match only after bit 0
    task automatic t_det(input logic act_sel, input logic [1:0] code);
        logic [7:0] pat;
        do_reset();
        reg_wr(`IBLCL_ADDR_LEN, act_sel ? {4'h0, code, 2'b01} : {6'h00, code});
        pat = act_sel ? act_p : deact_p;
        for (int i = 4 + int'(code); i >= 0; i--) begin
            @(posedge clk_sys);
            rx_bit <= pat[i];
            rx_en <= 1'b1;
        end
        #1 chk({6'h00, act_m, deact_m}, 8'h00);
        @(posedge clk_sys) rx_en <= 1'b0;
        #1;
        chk({6'h00, act_m, deact_m}, act_sel ? 8'h02 : 8'h01);
        $display("test det done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this limit leaves ample margin
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    initial begin
        t_reset_regs();
        t_fields();
        for (int c = 0; c < 4; c++) begin
            t_gen(2'(c));
            t_det(1'b1, 2'(c));
            t_det(1'b0, 2'(c));
        end
        final_report();
    end
endmodule
`default_nettype wire
